// file: rtl/pas_defines.svh
/*
  Register offsets, field positions and reset values for the PWM
  auto-shutdown and period sync block. Assumes inclusion by bare name.
*/
`ifndef PAS_DEFINES_SVH
`define PAS_DEFINES_SVH

// Register byte offsets on the APB
`define PAS_OFF_SDCTRL 12'h000
`define PAS_OFF_SDSRC 12'h004
`define PAS_OFF_SDLVL 12'h008
`define PAS_OFF_SYNC 12'h00c
`define PAS_OFF_STATUS 12'h010

// Shutdown control fields
`define PAS_SD_EN_BIT 7
`define PAS_SD_EVT_BIT 6
`define PAS_SD_ACT_BIT 5
`define PAS_SD_OVR_BIT 4
`define PAS_SD_ARS_BIT 3
`define PAS_SD_IRQ_BIT 2

// Sync control fields
`define PAS_SY_POFST_BIT 7
`define PAS_SY_PRPOL_BIT 6
`define PAS_SY_DCPOL_BIT 5
`define PAS_SY_SEL_MSB 2
`define PAS_SY_WMASK 8'he7

// Reset values
`define PAS_SDCTRL_RST 8'h00
`define PAS_SYNC_RST 8'h00
`define PAS_LVL_RST 8'h00
`define PAS_SRC_RST 8'h00

`endif

// file: rtl/pas_pkg.sv
/*
  Types shared by the auto-shutdown and sync block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package pas_pkg;

  // Restart state machine
  typedef enum logic [2:0] {
    PAS_RUN = 3'b001,
    PAS_SHUT = 3'b010,
    PAS_WAIT = 3'b100
  } pas_state_type;

  // Decoded sync control
  typedef struct packed {
    logic phase_offset_control;
    logic period_input_invert;
    logic duty_input_invert;
    logic [2:0] period_sync_select;
  } pas_sync_type;

  // Raw event inputs of the module
  typedef struct packed {
    logic period_event;
    logic phase_event;
    logic [3:0] period_async;
    logic [3:0] duty_async;
  } pas_event_type;

endpackage

// file: rtl/pas_sync_mux.sv
/*
  Sync source selection and async event polarity.
  Assumes sync outputs of four sibling instances arrive in pclk domain.
*/
`timescale 1ns/1ps
`include "pas_defines.svh"

module pas_sync_mux
  import pas_pkg::*;
#(
  parameter int N_IN = 4
) (
  // Control
  input wire pas_sync_type cfg,
  // Events
  input wire logic period_event,
  input wire logic phase_event,
  input wire logic [3:0] sib_sync,
  input wire logic [N_IN-1:0] period_async,
  input wire logic [N_IN-1:0] duty_async,
  // Results
  output logic sync_in,
  output logic sync_src,
  output logic latch_set,
  output logic [N_IN-1:0] period_pol,
  output logic [N_IN-1:0] duty_pol
);

  // Reserved codes select nothing, so no spurious sync
  wire sel_own = (cfg.period_sync_select == 3'h0);
  wire sel_sib = (cfg.period_sync_select >= 3'h1) && (cfg.period_sync_select <= 3'h4);
  wire [1:0] sib_idx = 2'(cfg.period_sync_select - 3'h1);

  // Source selection
  assign sync_in = sel_own ? period_event : (sel_sib ? sib_sync[sib_idx] : 1'b0);

  // Role swap by phase offset
  assign sync_src = cfg.phase_offset_control ? phase_event : period_event;
  assign latch_set = cfg.phase_offset_control ? sync_in : phase_event;

  // Polarity per input
  genvar i;
  generate
    for (i = 0; i < N_IN; i++) begin : g_pol
      assign period_pol[i] = period_async[i] ^ cfg.period_input_invert;
      assign duty_pol[i] = duty_async[i] ^ cfg.duty_input_invert;
    end
  endgenerate

endmodule

// file: rtl/pas_src_sel.sv
/*
  Gates the external shutdown sources by the source select mask.
  Assumes sources are synchronous levels.
*/
`timescale 1ns/1ps

module pas_src_sel #(
  parameter int N_SRC = 8
) (
  // Sources and mask
  input wire logic [N_SRC-1:0] src,
  input wire logic [N_SRC-1:0] mask,
  // Any selected source high
  output logic cond
);

  // Level sensitive OR of enabled sources
  assign cond = |(src & mask);

endmodule

// file: rtl/pas_top.sv
/*
  PWM auto-shutdown, override and period sync control with an APB slave.
  Assumes the PWM core supplies events and normal outputs in the pclk domain.
*/
`timescale 1ns/1ps
`include "pas_defines.svh"

// Operation
// - Enable bit gates every shutdown function; clear disables them all, but sd_irq stays set and pins in shutdown keep override levels until the next period event.
// - Software setting the event flag is a shutdown event.
// - Override stays on outputs while the event flag is set.
// - Source select register chooses which inputs may shut down.
// - Any selected source high sets event flag and interrupt request.
// - External sources act on level, not edge.
// - During shutdown each pin takes its programmed override level.
// - Forced override bit drives override levels without interrupt.
// - Auto-restart bit chooses manual or automatic restart.
// - Manual mode: active flag stays set until software clears it.
// - Manual mode: outputs resume at first period event after clear.
// - Auto mode: active flag clears itself once condition is gone.
// - Auto mode: outputs resume at next period event after that.
// - Software clear of active flag ignored while condition present.
// - Bit 7 swaps sync output and latch set sources.
// - Bit 6 inverts all async period inputs.
// - Bit 5 inverts all async duty inputs.
// - Select field 0 own period, 1 to 4 sibling sync outputs.
module pas_top
  import pas_pkg::*;
#(
  parameter int N_SRC = 8,
  parameter int N_OUT = 6,
  parameter int N_ASYNC = 4
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // PWM core side
  input wire logic period_event,
  input wire logic phase_event,
  input wire logic [3:0] sib_sync,
  input wire logic [N_ASYNC-1:0] period_async,
  input wire logic [N_ASYNC-1:0] duty_async,
  input wire logic [N_OUT-1:0] pwm_normal,
  input wire logic [N_SRC-1:0] sd_src,
  // Results
  output logic [N_OUT-1:0] pwm_out,
  output logic sd_irq,
  output logic sync_in_o,
  output logic sync_out_o,
  output logic latch_set_o,
  output logic [N_ASYNC-1:0] period_pol_o,
  output logic [N_ASYNC-1:0] duty_pol_o
);

  // Registers
  logic en_reg, evt_reg, act_reg, ovr_reg, ars_reg, irq_reg, sw_evt_reg;
  logic [N_SRC-1:0] src_reg;
  logic [N_OUT-1:0] lvl_reg;
  logic [7:0] sync_reg;
  pas_state_type state_reg, state_next;
  logic ready_reg;
  logic [31:0] rdata_reg;
  logic err_reg;

  // Bus decode; single wait state so pready is registered
  wire acc = psel && penable && !ready_reg;
  wire wr = acc && pwrite;
  wire hit_ctl = (paddr == `PAS_OFF_SDCTRL);
  wire hit_src = (paddr == `PAS_OFF_SDSRC);
  wire hit_lvl = (paddr == `PAS_OFF_SDLVL);
  wire hit_syn = (paddr == `PAS_OFF_SYNC);
  wire hit_sta = (paddr == `PAS_OFF_STATUS);
  wire hit_any = hit_ctl | hit_src | hit_lvl | hit_syn | hit_sta;
  wire wr_ctl = wr && hit_ctl;

  // External condition, gated by enable
  logic ext_cond;
  pas_src_sel #(.N_SRC(N_SRC)) u_src (
    .src(sd_src),
    .mask(src_reg),
    .cond(ext_cond)
  );
  wire cond = en_reg && ext_cond;

  // Software writes to event, active and interrupt flags
  wire sw_evt_set = wr_ctl && pwdata[`PAS_SD_EVT_BIT];
  wire sw_evt_clr = wr_ctl && !pwdata[`PAS_SD_EVT_BIT];
  wire sw_act_clr = wr_ctl && !pwdata[`PAS_SD_ACT_BIT];
  wire sw_irq_clr = wr_ctl && !pwdata[`PAS_SD_IRQ_BIT];

  // Software request kept apart, so auto-restart drops only hardware events
  wire sw_evt_next = en_reg && (sw_evt_set || (sw_evt_reg && !sw_evt_clr));
  wire auto_drop = ars_reg && !sw_evt_reg;
  // Event flag: hardware set wins over software clear
  wire evt_next = en_reg && (cond || sw_evt_set ||
                             (evt_reg && !sw_evt_clr && !auto_drop));
  // Shutdown held by the event flag as it stands after this edge, so one
  // write that clears event and active flags together takes effect
  wire hold = evt_next;
  // Active flag clear: blocked while condition present
  wire act_clr_ok = sw_act_clr && !hold;
  wire auto_clr = ars_reg && !hold;
  wire act_next = en_reg && (hold || (act_reg && !(ars_reg ? auto_clr : act_clr_ok)));
  // Sticky interrupt, cleared by writing zero; set wins
  wire irq_next = cond || (irq_reg && !sw_irq_clr);

  // Restart state machine
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      PAS_RUN: begin
        if (act_next) begin
          state_next = PAS_SHUT;
        end
      end
      PAS_SHUT: begin
        if (!act_next) begin
          state_next = PAS_WAIT;
        end
      end
      PAS_WAIT: begin
        if (act_next) begin
          state_next = PAS_SHUT;
        end else if (period_event) begin
          state_next = PAS_RUN;
        end
      end
    endcase
  end

  wire shut_out = (state_next != PAS_RUN) || (en_reg && ovr_reg);
  wire [N_OUT-1:0] out_next = shut_out ? lvl_reg : pwm_normal;

  // Sync role and polarity logic
  pas_sync_type cfg;
  assign cfg = '{sync_reg[`PAS_SY_POFST_BIT], sync_reg[`PAS_SY_PRPOL_BIT],
                 sync_reg[`PAS_SY_DCPOL_BIT], sync_reg[`PAS_SY_SEL_MSB:0]};
  logic sync_in_w, sync_src_w, latch_w;
  logic [N_ASYNC-1:0] ppol_w, dpol_w;
  pas_sync_mux #(.N_IN(N_ASYNC)) u_sync (
    .cfg(cfg),
    .period_event(period_event),
    .phase_event(phase_event),
    .sib_sync(sib_sync),
    .period_async(period_async),
    .duty_async(duty_async),
    .sync_in(sync_in_w),
    .sync_src(sync_src_w),
    .latch_set(latch_w),
    .period_pol(ppol_w),
    .duty_pol(dpol_w)
  );

  // Read mux
  wire [7:0] ctl_rd = {en_reg, evt_reg, act_reg, ovr_reg, ars_reg, irq_reg, 2'b00};
  wire [31:0] rd_mux = hit_ctl ? {24'h0, ctl_rd} :
                       hit_src ? 32'(src_reg) :
                       hit_lvl ? 32'(lvl_reg) :
                       hit_syn ? {24'h0, sync_reg} :
                       hit_sta ? {29'h0, state_reg} : 32'h0;

  // APB handshake registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_reg <= 1'b0;
      rdata_reg <= 32'h0;
      err_reg <= 1'b0;
    end else begin
      ready_reg <= psel && penable && !ready_reg;
      rdata_reg <= (acc && !pwrite) ? rd_mux : rdata_reg;
      err_reg <= acc && !hit_any; // Unmapped address answered with error
    end
  end

  // Shutdown control and configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_reg <= 1'b0;
      ovr_reg <= 1'b0;
      ars_reg <= 1'b0;
      src_reg <= '0;
      lvl_reg <= '0;
      sync_reg <= `PAS_SYNC_RST;
    end else begin
      if (wr_ctl) begin
        en_reg <= pwdata[`PAS_SD_EN_BIT];
        ovr_reg <= pwdata[`PAS_SD_OVR_BIT];
        ars_reg <= pwdata[`PAS_SD_ARS_BIT];
      end
      if (wr && hit_src) begin
        src_reg <= pwdata[N_SRC-1:0];
      end
      if (wr && hit_lvl) begin
        lvl_reg <= pwdata[N_OUT-1:0];
      end
      if (wr && hit_syn) begin
        sync_reg <= pwdata[7:0] & `PAS_SY_WMASK;
      end
    end
  end

  // Flags, state and outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_reg <= 1'b0;
      sw_evt_reg <= 1'b0;
      act_reg <= 1'b0;
      irq_reg <= 1'b0;
      state_reg <= PAS_RUN;
      pwm_out <= '0;
    end else begin
      evt_reg <= evt_next;
      sw_evt_reg <= sw_evt_next;
      act_reg <= act_next;
      irq_reg <= irq_next;
      state_reg <= state_next;
      pwm_out <= out_next;
    end
  end

  // Registered sync outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_in_o <= 1'b0;
      sync_out_o <= 1'b0;
      latch_set_o <= 1'b0;
      period_pol_o <= '0;
      duty_pol_o <= '0;
    end else begin
      sync_in_o <= sync_in_w;
      sync_out_o <= sync_src_w;
      latch_set_o <= latch_w;
      period_pol_o <= ppol_w;
      duty_pol_o <= dpol_w;
    end
  end

  assign prdata = rdata_reg;
  assign pready = ready_reg;
  assign pslverr = err_reg;
  assign sd_irq = irq_reg;

  // Assertions
  property p_dis;
    @(posedge pclk) disable iff (!presetn) !en_reg |=> !act_reg && !evt_reg;
  endproperty
  a_dis: assert property (p_dis) else $error("shutdown active while disabled");

  property p_ext;
    @(posedge pclk) disable iff (!presetn) (en_reg && ext_cond) |=> evt_reg && act_reg && irq_reg;
  endproperty
  a_ext: assert property (p_ext) else $error("source did not raise shutdown");

  property p_lvl;
    @(posedge pclk) disable iff (!presetn) (act_reg && $stable(lvl_reg)) |-> pwm_out == lvl_reg;
  endproperty
  a_lvl: assert property (p_lvl) else $error("override level missing");

  property p_ovr_noirq;
    @(posedge pclk) disable iff (!presetn)
      (en_reg && ovr_reg && !ext_cond && !irq_reg && !sw_evt_set) |=> !irq_reg;
  endproperty
  a_ovr_noirq: assert property (p_ovr_noirq) else $error("override raised irq");

  property p_manual;
    @(posedge pclk) disable iff (!presetn)
      (act_reg && en_reg && !ars_reg && !wr_ctl) |=> act_reg;
  endproperty
  a_manual: assert property (p_manual) else $error("manual flag self cleared");

  property p_noclr;
    @(posedge pclk) disable iff (!presetn) (hold && act_reg) |=> act_reg;
  endproperty
  a_noclr: assert property (p_noclr) else $error("active cleared under condition");

  property p_restart;
    @(posedge pclk) disable iff (!presetn)
      (state_reg == PAS_WAIT && period_event && !act_next) |=> state_reg == PAS_RUN;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart at period");

  property p_sticky;
    @(posedge pclk) disable iff (!presetn) (irq_reg && !sw_irq_clr) |=> irq_reg;
  endproperty
  a_sticky: assert property (p_sticky) else $error("irq lost");

  property p_res;
    @(posedge pclk) disable iff (!presetn) sync_reg[4:3] == 2'b00;
  endproperty
  a_res: assert property (p_res) else $error("reserved sync bits set");

  property p_sw_evt;
    @(posedge pclk) disable iff (!presetn) (en_reg && sw_evt_set) |=> evt_reg && act_reg;
  endproperty
  a_sw_evt: assert property (p_sw_evt) else $error("software event ignored");

  property p_evt_hold;
    @(posedge pclk) disable iff (!presetn)
      (evt_reg && $stable(lvl_reg)) |-> pwm_out == lvl_reg;
  endproperty
  a_evt_hold: assert property (p_evt_hold) else $error("override left early");

  property p_auto;
    @(posedge pclk) disable iff (!presetn)
      (en_reg && ars_reg && !ext_cond && !sw_evt_reg && !sw_evt_set) |=> !act_reg && !evt_reg;
  endproperty
  a_auto: assert property (p_auto) else $error("auto restart kept shutdown");

  property p_wait;
    @(posedge pclk) disable iff (!presetn)
      (state_reg != PAS_RUN && !period_event) |=> state_reg != PAS_RUN;
  endproperty
  a_wait: assert property (p_wait) else $error("restart off the period event");

  property p_resume;
    @(posedge pclk) disable iff (!presetn)
      (state_reg == PAS_WAIT && period_event && !act_next && !ovr_reg) |=>
        pwm_out == $past(pwm_normal);
  endproperty
  a_resume: assert property (p_resume) else $error("normal output not resumed");

  property p_sync_own;
    @(posedge pclk) disable iff (!presetn)
      (sync_reg[`PAS_SY_SEL_MSB:0] == 3'h0) |=> sync_in_o == $past(period_event);
  endproperty
  a_sync_own: assert property (p_sync_own) else $error("own period sync lost");

  property p_role_ph;
    @(posedge pclk) disable iff (!presetn)
      sync_reg[`PAS_SY_POFST_BIT] |=> sync_out_o == $past(phase_event);
  endproperty
  a_role_ph: assert property (p_role_ph) else $error("sync output role wrong");

  property p_role_lt;
    @(posedge pclk) disable iff (!presetn)
      !sync_reg[`PAS_SY_POFST_BIT] |=> latch_set_o == $past(phase_event);
  endproperty
  a_role_lt: assert property (p_role_lt) else $error("latch set role wrong");

  property p_pol_per;
    @(posedge pclk) disable iff (!presetn)
      sync_reg[`PAS_SY_PRPOL_BIT] |=> period_pol_o == ~$past(period_async);
  endproperty
  a_pol_per: assert property (p_pol_per) else $error("period input not inverted");

  property p_pol_dut;
    @(posedge pclk) disable iff (!presetn)
      !sync_reg[`PAS_SY_DCPOL_BIT] |=> duty_pol_o == $past(duty_async);
  endproperty
  a_pol_dut: assert property (p_pol_dut) else $error("duty input altered");

  c_shut: cover property (@(posedge pclk) disable iff (!presetn) $rose(act_reg));
  c_auto: cover property (@(posedge pclk) disable iff (!presetn) ars_reg && $fell(act_reg));
  c_run: cover property (@(posedge pclk) disable iff (!presetn)
    state_reg == PAS_WAIT ##1 state_reg == PAS_RUN);
  c_force: cover property (@(posedge pclk) disable iff (!presetn)
    en_reg && ovr_reg && !act_reg);
  c_swap: cover property (@(posedge pclk) disable iff (!presetn)
    sync_reg[`PAS_SY_POFST_BIT] && phase_event);

endmodule

// file: tb/pas_partner.sv
/*
  Far side model: shutdown sources, period events, normal PWM levels.
  Assumes one pclk domain and an active-low asynchronous reset.
*/
`timescale 1ns/1ps

module pas_partner #(
  parameter int PERIOD = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench request
  input wire logic [7:0] src_req,
  // Toward the block
  output logic [7:0] sd_src,
  output logic period_event,
  output logic [5:0] pwm_normal
);
  logic [3:0] cnt_reg;
  logic wrap;

  // Fixed normal level, distinct from any override pattern used
  assign pwm_normal = 6'h33;
  assign wrap = (cnt_reg == 4'(PERIOD - 1));

  // Sources stay at their level while requested, never a pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 4'h0;
      sd_src <= 8'h00;
      period_event <= 1'b0;
    end else begin
      cnt_reg <= wrap ? 4'h0 : cnt_reg + 4'h1;
      sd_src <= src_req;
      period_event <= wrap;
    end
  end
endmodule

// file: tb/tb_pas_top.sv
/*
  Self-checking bench for the auto-shutdown and sync block.
  Assumes pas_partner supplies sources, period events and normal levels.
*/
`timescale 1ns/1ps
`include "pas_defines.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end

module tb_pas_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, phase_event = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, period_event, er, sd_irq, sync_in_o, sync_out_o, latch_set_o;
  logic [3:0] sib_sync = '0, period_async = '0, duty_async = '0, period_pol_o, duty_pol_o;
  logic [5:0] pwm_normal, pwm_out;
  logic [7:0] src_req = '0, sd_src;
  int n_fail = 0, n_compared = 0;

  always #25 pclk = ~pclk;

  pas_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .period_event(period_event), .phase_event(phase_event),
    .sib_sync(sib_sync), .period_async(period_async), .duty_async(duty_async),
    .pwm_normal(pwm_normal), .sd_src(sd_src), .pwm_out(pwm_out), .sd_irq(sd_irq),
    .sync_in_o(sync_in_o), .sync_out_o(sync_out_o), .latch_set_o(latch_set_o),
    .period_pol_o(period_pol_o), .duty_pol_o(duty_pol_o));

  pas_partner partner (.pclk(pclk), .presetn(presetn), .src_req(src_req),
    .sd_src(sd_src), .period_event(period_event), .pwm_normal(pwm_normal));

  task automatic test_done;
    $display("Compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i >= 20) begin
      n_fail++;
      test_done;
    end
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] m, e, input string nm);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, rd & m)
  endtask

  task automatic do_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  // Bounded wait for the next period event, then let outputs settle
  task automatic wait_period(input int settle);
    int i;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (period_event !== 1'b1 && i < 40);
    if (i >= 40) begin
      n_fail++;
      test_done;
    end
    repeat (settle) @(posedge pclk);
  endtask

  task automatic t_regs;
    rdchk(`PAS_OFF_SDCTRL, 32'hffffffff, 32'h0, "ctrl rst");
    rdchk(`PAS_OFF_SYNC, 32'hffffffff, 32'h0, "sync rst");
    // Select field kept to a legal code; reserved codes are off limits
    apb(1'b1, `PAS_OFF_SYNC, 32'hfc);
    rdchk(`PAS_OFF_SYNC, 32'hffffffff, 32'he4, "sync ro");
    rdchk(12'h020, 32'hffffffff, 32'h0, "unmapped rd");
    `CHK("unmapped err", 1'b1, er)
  endtask

  task automatic t_sync;
    for (int k = 1; k <= 4; k++) begin
      apb(1'b1, `PAS_OFF_SYNC, k);
      sib_sync <= 4'h1 << (k - 1);
      repeat (3) @(posedge pclk);
      `CHK("sync sel", 1'b1, sync_in_o)
      sib_sync <= ~(4'h1 << (k - 1));
      repeat (3) @(posedge pclk);
      `CHK("sync other", 1'b0, sync_in_o)
    end
    // Own period event, seen one edge after it is sampled
    apb(1'b1, `PAS_OFF_SYNC, 32'h00);
    wait_period(1);
    `CHK("sync own", 1'b1, sync_in_o)
    period_async <= 4'h5;
    duty_async <= 4'h3;
    apb(1'b1, `PAS_OFF_SYNC, 32'h40);
    repeat (3) @(posedge pclk);
    `CHK("per inv", 4'ha, period_pol_o)
    `CHK("duty thru", 4'h3, duty_pol_o)
    apb(1'b1, `PAS_OFF_SYNC, 32'h20);
    repeat (3) @(posedge pclk);
    `CHK("per thru", 4'h5, period_pol_o)
    `CHK("duty inv", 4'hc, duty_pol_o)
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, `PAS_OFF_SYNC, k ? 32'h80 : 32'h00);
      @(posedge pclk);
      phase_event <= 1'b1;
      @(posedge pclk);
      phase_event <= 1'b0;
      #1;
      `CHK("phase route", 1'b1, k ? sync_out_o : latch_set_o)
    end
  endtask

  task automatic t_soft;
    do_reset;
    apb(1'b1, `PAS_OFF_SDLVL, 32'h0c);
    apb(1'b1, `PAS_OFF_SDCTRL, 32'h40);
    repeat (3) @(posedge pclk);
    `CHK("disabled", 6'h33, pwm_out)
    // Enable must already stand when the event bit is written
    apb(1'b1, `PAS_OFF_SDCTRL, 32'h80);
    apb(1'b1, `PAS_OFF_SDCTRL, 32'hc0);
    repeat (3) @(posedge pclk);
    `CHK("sw shut", 6'h0c, pwm_out)
    repeat (20) @(posedge pclk);
    `CHK("sw held", 6'h0c, pwm_out)
  endtask

  task automatic t_ext_manual;
    do_reset;
    apb(1'b1, `PAS_OFF_SDLVL, 32'h0c);
    apb(1'b1, `PAS_OFF_SDSRC, 32'h01);
    apb(1'b1, `PAS_OFF_SDCTRL, 32'h80);
    src_req <= 8'h02;
    repeat (4) @(posedge pclk);
    `CHK("masked", 6'h33, pwm_out)
    src_req <= 8'h01;
    repeat (4) @(posedge pclk);
    `CHK("ext shut", 6'h0c, pwm_out)
    `CHK("ext irq", 1'b1, sd_irq)
    apb(1'b1, `PAS_OFF_SDCTRL, 32'h84);
    rdchk(`PAS_OFF_SDCTRL, 32'h20, 32'h20, "clr ignored");
    src_req <= 8'h00;
    repeat (20) @(posedge pclk);
    rdchk(`PAS_OFF_SDCTRL, 32'h24, 32'h24, "sticky");
    apb(1'b1, `PAS_OFF_SDCTRL, 32'h80);
    wait_period(3);
    `CHK("man restart", 6'h33, pwm_out)
  endtask

  task automatic t_ext_auto;
    do_reset;
    apb(1'b1, `PAS_OFF_SDLVL, 32'h0c);
    apb(1'b1, `PAS_OFF_SDSRC, 32'h01);
    apb(1'b1, `PAS_OFF_SDCTRL, 32'h88);
    src_req <= 8'h01;
    repeat (4) @(posedge pclk);
    `CHK("auto shut", 6'h0c, pwm_out)
    src_req <= 8'h00;
    repeat (4) @(posedge pclk);
    rdchk(`PAS_OFF_SDCTRL, 32'h20, 32'h0, "auto clr");
    wait_period(3);
    `CHK("auto restart", 6'h33, pwm_out)
    `CHK("auto irq kept", 1'b1, sd_irq)
  endtask

  task automatic t_force;
    do_reset;
    apb(1'b1, `PAS_OFF_SDLVL, 32'h0c);
    apb(1'b1, `PAS_OFF_SDCTRL, 32'h90);
    repeat (3) @(posedge pclk);
    `CHK("forced", 6'h0c, pwm_out)
    `CHK("forced irq", 1'b0, sd_irq)
    // Override bit left set, enable cleared: pins go back to normal
    apb(1'b1, `PAS_OFF_SDCTRL, 32'h10);
    repeat (3) @(posedge pclk);
    `CHK("force off", 6'h33, pwm_out)
  endtask

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_sync;
    t_soft;
    t_ext_manual;
    t_ext_auto;
    t_force;
    test_done;
  end
endmodule
